// ==== logic/cell_balance_params.svh ====
`ifndef CELL_BALANCE_PARAMS_SVH
`define CELL_BALANCE_PARAMS_SVH

// register offsets
`define CBAL_CFG_ADDR 8'h0A
`define NV_KEY_ADDR 8'h0B
`define NV_CFG_FIRST 8'h01
`define NV_CFG_LAST 8'h0A
// key values
`define NV_KEY_WRITE 8'h41
`define NV_KEY_PREREAD 8'h62
`define NV_KEY_RESET 8'h00
`define CBAL_CFG_RESET 8'h00
// cell_balance_config field positions
`define MODE_MSB 7
`define MODE_LSB 6
`define TMO_MSB 5
`define TMO_LSB 4
`define THR_MSB 3
`define THR_LSB 0
// balance mode codes
`define MODE_OFF 2'h0
`define MODE_ALWAYS 2'h1
`define MODE_CHG 2'h2
`define MODE_CHG_TMO 2'h3
// threshold in millivolts
`define THR_TOP_MV 3900
`define THR_STEP_MV 100
// time base
`define CLK_HZ 25000000
`define HOUR_S 3600
`define SEC_CYCLES (`CLK_HZ)
`define BASE_HOURS_SEC (`HOUR_S)

`endif

// ==== logic/cell_balance_pkg.sv ====
`default_nettype none
package cell_balance_pkg;
    typedef enum logic [1:0] {
        BAL_IDLE,
        BAL_ACTIVE,
        BAL_LOCKOUT
    } bal_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] timeout;
        logic [3:0] threshold;
    } bal_cfg_t;

    typedef struct packed {
        logic charge_fet_drive;
        logic discharge_fet_drive;
    } fet_drive_t;
endpackage
`default_nettype wire

// ==== logic/cell_balance_nvm.sv ====
// Operation
// - mode 00 never balances; 01 timed balancing
// - mode 01 rearms after all cells drop
// - mode 10 balances only while charger present
// - mode 11 stops on removal or expiry
// - timer starts when bleed actually starts
// - enable only permits voltage-driven bleed decisions
// - timeout codes select 1,2,4,8 hours
// - threshold 3.9 V down 0.1 V steps
// - start when any cell reaches threshold
// - key 41h enables config writes to 0Ah only
// - key 62h enables pre-read of stored data
// - key register resets to zero
// - host lines enabled only while comm pin high
// - parity mismatch forces both FETs off
`timescale 1ns/1ps
`include "cell_balance_params.svh"
`default_nettype none

module cell_balance_nvm #(
    parameter int CELLS = 10,
    parameter int SEC_CYCLES = `SEC_CYCLES,
    parameter int HOUR_SECONDS = `BASE_HOURS_SEC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic comm_enable_pin,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_wr,
    input wire logic host_rd,
    output logic [7:0] host_rdata,
    output logic host_lines_en,
    input wire logic program_pin,
    input wire logic parity_error,
    input wire logic charger_present,
    input wire logic [CELLS*12-1:0] cell_mv,
    input wire logic fet_request_chg,
    input wire logic fet_request_dsg,
    output logic [CELLS-1:0] bleed_en,
    output logic balance_active,
    output logic nv_commit,
    output logic nv_preread_en,
    output logic cfg_write_en,
    output cell_balance_pkg::fet_drive_t fet_drive
);
    // threshold in mV from code
    function automatic logic [11:0] thr_mv(input logic [3:0] code);
        thr_mv = 12'(`THR_TOP_MV) - 12'(`THR_STEP_MV) * {8'h00, code};
    endfunction

    // timeout in hours: 1,2,4,8
    function automatic logic [3:0] tmo_hours(input logic [1:0] code);
        tmo_hours = 4'h1 << code;
    endfunction

    // pin synchronisers: pins arrive from outside the clock domain
    logic [1:0] comm_sync_reg, prog_sync_reg, chg_sync_reg, par_sync_reg;
    logic prog_last_reg;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            comm_sync_reg <= 2'h0;
            prog_sync_reg <= 2'h0;
            chg_sync_reg <= 2'h0;
            par_sync_reg <= 2'h0;
            prog_last_reg <= 1'b0;
        end else begin
            comm_sync_reg <= {comm_sync_reg[0], comm_enable_pin};
            prog_sync_reg <= {prog_sync_reg[0], program_pin};
            chg_sync_reg <= {chg_sync_reg[0], charger_present};
            par_sync_reg <= {par_sync_reg[0], parity_error};
            prog_last_reg <= prog_sync_reg[1];
        end
    end
    wire logic comm_on = comm_sync_reg[1];
    wire logic chg_on = chg_sync_reg[1];

    // register file
    cell_balance_pkg::bal_cfg_t cfg_reg, cfg_next;
    logic [7:0] key_reg, key_next, rdata_reg, rdata_next;
    logic commit_reg, commit_next;
    wire logic key_write = (key_reg == `NV_KEY_WRITE);
    wire logic key_preread = (key_reg == `NV_KEY_PREREAD);
    // falling edge of program pin ends the high-then-low strobe
    wire logic prog_fall = prog_last_reg & ~prog_sync_reg[1];

    always_comb begin
        cfg_next = cfg_reg;
        key_next = key_reg;
        rdata_next = rdata_reg;
        commit_next = prog_fall & key_write;
        // host access is dead while the enable pin is low
        if (comm_on && host_wr) begin
            if (host_addr == `NV_KEY_ADDR) begin
                key_next = host_wdata;
            end else if (host_addr == `CBAL_CFG_ADDR && key_write) begin
                cfg_next = host_wdata;
            end
        end
        if (comm_on && host_rd) begin
            if (host_addr == `CBAL_CFG_ADDR) begin
                rdata_next = cfg_reg;
            end else if (host_addr == `NV_KEY_ADDR) begin
                rdata_next = key_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfg_reg <= `CBAL_CFG_RESET;
            key_reg <= `NV_KEY_RESET;
            rdata_reg <= 8'h00;
            commit_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            key_reg <= key_next;
            rdata_reg <= rdata_next;
            commit_reg <= commit_next;
        end
    end

    // per-cell compare against the threshold
    logic [CELLS-1:0] above;
    always_comb begin
        for (int i = 0; i < CELLS; i++) begin
            above[i] = cell_mv[i*12 +: 12] >= thr_mv(cfg_reg.threshold);
        end
    end
    wire logic any_above = |above;
    wire logic gated = (cfg_reg.mode == `MODE_CHG) || (cfg_reg.mode == `MODE_CHG_TMO);
    wire logic timed = (cfg_reg.mode == `MODE_ALWAYS) || (cfg_reg.mode == `MODE_CHG_TMO);
    wire logic permit = (cfg_reg.mode != `MODE_OFF) && (!gated || chg_on);

    // balance state machine with hour timer
    cell_balance_pkg::bal_state_t st_reg, st_next;
    logic [31:0] sec_reg, sec_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [3:0] hrs_reg, hrs_next;
    logic [CELLS-1:0] bleed_reg, bleed_next;

    always_comb begin
        st_next = st_reg;
        sec_next = sec_reg;
        cnt_next = cnt_reg;
        hrs_next = hrs_reg;
        bleed_next = '0;
        case (st_reg)
            cell_balance_pkg::BAL_IDLE: begin
                sec_next = 32'h0;
                cnt_next = 32'h0;
                hrs_next = 4'h0;
                // enabling alone diverts nothing; voltage decides
                if (permit && any_above) begin
                    st_next = cell_balance_pkg::BAL_ACTIVE;
                end
            end
            cell_balance_pkg::BAL_ACTIVE: begin
                bleed_next = above;
                // divided time base: seconds, then hours
                if (sec_reg == 32'(SEC_CYCLES - 1)) begin
                    sec_next = 32'h0;
                    if (cnt_reg == 32'(HOUR_SECONDS - 1)) begin
                        cnt_next = 32'h0;
                        hrs_next = hrs_reg + 4'h1;
                    end else begin
                        cnt_next = cnt_reg + 32'h1;
                    end
                end else begin
                    sec_next = sec_reg + 32'h1;
                end
                if (!permit) begin
                    st_next = cell_balance_pkg::BAL_IDLE;
                    bleed_next = '0;
                end else if (timed && hrs_reg == tmo_hours(cfg_reg.timeout)) begin
                    st_next = cell_balance_pkg::BAL_LOCKOUT;
                    bleed_next = '0;
                end
            end
            cell_balance_pkg::BAL_LOCKOUT: begin
                sec_next = 32'h0;
                cnt_next = 32'h0;
                hrs_next = 4'h0;
                // always mode rearms when all cells fall below; charger
                // modes rearm only after the charger goes away
                if (cfg_reg.mode == `MODE_ALWAYS) begin
                    if (!any_above) st_next = cell_balance_pkg::BAL_IDLE;
                end else if (!permit) begin
                    st_next = cell_balance_pkg::BAL_IDLE;
                end
            end
            default: st_next = cell_balance_pkg::BAL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_reg <= cell_balance_pkg::BAL_IDLE;
            sec_reg <= 32'h0;
            cnt_reg <= 32'h0;
            hrs_reg <= 4'h0;
            bleed_reg <= '0;
        end else begin
            st_reg <= st_next;
            sec_reg <= sec_next;
            cnt_reg <= cnt_next;
            hrs_reg <= hrs_next;
            bleed_reg <= bleed_next;
        end
    end

    // registered outputs; parity fault overrides FET requests
    cell_balance_pkg::fet_drive_t fet_reg, fet_next;
    logic lines_reg, act_reg, pre_reg, wen_reg;
    always_comb begin
        fet_next.charge_fet_drive = fet_request_chg & ~par_sync_reg[1];
        fet_next.discharge_fet_drive = fet_request_dsg & ~par_sync_reg[1];
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fet_reg <= '0;
            lines_reg <= 1'b0;
            act_reg <= 1'b0;
            pre_reg <= 1'b0;
            wen_reg <= 1'b0;
        end else begin
            fet_reg <= fet_next;
            lines_reg <= comm_on;
            act_reg <= (st_next == cell_balance_pkg::BAL_ACTIVE);
            pre_reg <= key_preread;
            wen_reg <= key_write;
        end
    end

    assign host_rdata = rdata_reg;
    assign host_lines_en = lines_reg;
    assign bleed_en = bleed_reg;
    assign balance_active = act_reg;
    assign nv_commit = commit_reg;
    assign nv_preread_en = pre_reg;
    assign cfg_write_en = wen_reg;
    assign fet_drive = fet_reg;
endmodule

`default_nettype wire

// ==== verif/cell_balance_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module cell_balance_chk #(parameter int CELLS = 10) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic comm_enable_pin,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_wr,
    input wire logic host_lines_en,
    input wire logic parity_error,
    input wire logic [CELLS-1:0] bleed_en,
    input wire logic balance_active,
    input wire logic nv_commit,
    input wire logic nv_preread_en,
    input wire logic cfg_write_en,
    input wire cell_balance_pkg::fet_drive_t fet_drive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // key write strobe; the port takes it only once the pin has passed two flops
    wire logic key_wr = host_wr && host_addr == 8'h0B;
    a_fet_parity_off: assert property (parity_error [*4] |=> fet_drive == 2'h0)
        else $error("fets on in parity fault");
    a_lines_comm_low: assert property (!comm_enable_pin [*4] |=> !host_lines_en)
        else $error("host lines on, pin low");
    a_commit_needs_key: assert property (nv_commit |-> cfg_write_en)
        else $error("commit without key");
    a_commit_one_cycle: assert property (nv_commit |=> !nv_commit)
        else $error("commit pulse too long");
    a_write_key_sets: assert property (key_wr && host_wdata == 8'h41
        && $past(comm_enable_pin, 2) && $past(rstn) && $past(rstn, 2) |-> ##2 cfg_write_en)
        else $error("write key not taken");
    a_preread_key: assert property (key_wr && host_wdata == 8'h62
        && $past(comm_enable_pin, 2) && $past(rstn) && $past(rstn, 2) |-> ##2 nv_preread_en)
        else $error("preread key not taken");
    a_bleed_when_active: assert property (|bleed_en |-> $past(balance_active))
        else $error("bleed without balancing");
    a_reset_clears: assert property ($rose(rstn) |-> !cfg_write_en && !nv_preread_en)
        else $error("key not cleared");
    c_balance: cover property ($rose(balance_active));
    c_commit: cover property (nv_commit);
    c_parity: cover property (parity_error && fet_drive == 2'h0);
endmodule
`default_nettype wire

// ==== verif/cell_balance_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module cell_balance_host (
    input wire logic core_clk,
    input wire logic [7:0] host_rdata,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    output logic host_wr,
    output logic host_rd,
    output logic program_pin
);
    // idle bus shows inverted last value, never a stale copy
    initial begin
        host_addr = 8'h00;
        host_wdata = 8'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        program_pin = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge core_clk);
        host_wr = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge core_clk);
        host_rd = 1'b0;
        host_addr = ~a;
        @(negedge core_clk);
        d = host_rdata;
    endtask
    // strobe high then low after loading and keying
    task automatic commit();
        @(negedge core_clk);
        program_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        program_pin = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/test_cell_balance_nvm.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_cell_balance_nvm;
    localparam int CELLS = 2;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] host_addr, host_wdata, host_rdata, rv;
    logic host_wr, host_rd, host_lines_en, program_pin, balance_active;
    logic comm_enable_pin = 1'b1;
    logic parity_error = 1'b0;
    logic charger_present = 1'b0;
    logic fet_request_chg = 1'b1;
    logic fet_request_dsg = 1'b1;
    logic [CELLS*12-1:0] cell_mv = '0;
    logic [CELLS-1:0] bleed_en;
    logic nv_commit, nv_preread_en, cfg_write_en;
    cell_balance_pkg::fet_drive_t fet_drive;
    int n_mismatch = 0;
    int compares = 0;
    int n_commit = 0;
    always #20 core_clk = ~core_clk;
    // look at the pulse mid-cycle, where it is settled
    always @(negedge core_clk) if (nv_commit === 1'b1) n_commit++;
    cell_balance_host host (
        .core_clk(core_clk),
        .host_rdata(host_rdata),
        .host_addr(host_addr),
        .host_wdata(host_wdata),
        .host_wr(host_wr),
        .host_rd(host_rd),
        .program_pin(program_pin)
    );
    cell_balance_nvm #(.CELLS(CELLS), .SEC_CYCLES(4), .HOUR_SECONDS(2)) dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .comm_enable_pin(comm_enable_pin),
        .host_addr(host_addr),
        .host_wdata(host_wdata),
        .host_wr(host_wr),
        .host_rd(host_rd),
        .host_rdata(host_rdata),
        .host_lines_en(host_lines_en),
        .program_pin(program_pin),
        .parity_error(parity_error),
        .charger_present(charger_present),
        .cell_mv(cell_mv),
        .fet_request_chg(fet_request_chg),
        .fet_request_dsg(fet_request_dsg),
        .bleed_en(bleed_en),
        .balance_active(balance_active),
        .nv_commit(nv_commit),
        .nv_preread_en(nv_preread_en),
        .cfg_write_en(cfg_write_en),
        .fet_drive(fet_drive)
    );
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // wait, then look at the balancing flag
    task automatic act(input logic e, input int n);
        cyc(n);
        chk("active", {7'h00, balance_active}, {7'h00, e});
    endtask
    // second cell stays low so only cell 0 can trip
    task automatic cells(input logic [11:0] v);
        @(negedge core_clk);
        cell_mv = {12'h7D0, v};
    endtask
    initial begin
        cyc(16);
        rstn = 1'b1;
        cyc(4);
        host.rd(8'h0B, rv);
        chk("key", rv, 8'h00);
        host.wr(8'h0A, 8'h40);
        host.rd(8'h0A, rv);
        chk("cfg locked", rv, 8'h00);
        host.wr(8'h0B, 8'h41);
        host.wr(8'h0A, 8'h40);
        host.rd(8'h0A, rv);
        chk("cfg", rv, 8'h40);
        cells(12'hF3B);
        act(1'b0, 4);
        cells(12'hF3C);
        cyc(3);
        chk("bleed", {6'h00, bleed_en}, 8'h01);
        act(1'b1, 3);
        act(1'b0, 6);
        act(1'b0, 4);
        cells(12'h7D0);
        cyc(2);
        cells(12'hF3C);
        act(1'b1, 3);
        host.wr(8'h0A, 8'h00);
        act(1'b0, 3);
        host.wr(8'h0A, 8'h8F);
        act(1'b0, 4);
        cells(12'h95F);
        charger_present = 1'b1;
        act(1'b0, 5);
        cells(12'h960);
        act(1'b1, 3);
        charger_present = 1'b0;
        act(1'b0, 5);
        // threshold 2.4 V so the cell left at 2400 mV trips in mode 11
        host.wr(8'h0A, 8'hDF);
        charger_present = 1'b1;
        act(1'b1, 5);
        act(1'b1, 9);
        act(1'b0, 9);
        charger_present = 1'b0;
        cyc(4);
        charger_present = 1'b1;
        act(1'b1, 5);
        host.wr(8'h0B, 8'h62);
        cyc(2);
        chk("keys", {6'h00, nv_preread_en, cfg_write_en}, 8'h02);
        host.commit();
        cyc(6);
        chk("commits", n_commit[7:0], 8'h00);
        host.wr(8'h0B, 8'h41);
        host.commit();
        cyc(6);
        chk("commits", n_commit[7:0], 8'h01);
        comm_enable_pin = 1'b0;
        cyc(4);
        chk("lines", {7'h00, host_lines_en}, 8'h00);
        host.wr(8'h0A, 8'h00);
        comm_enable_pin = 1'b1;
        cyc(4);
        host.rd(8'h0A, rv);
        chk("cfg kept", rv, 8'hDF);
        chk("fets", {6'h00, fet_drive}, 8'h03);
        parity_error = 1'b1;
        cyc(6);
        chk("fets", {6'h00, fet_drive}, 8'h00);
        // second reset in mid-run, key held at 41h, must clear it again
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(4);
        host.rd(8'h0B, rv);
        chk("key after reset", rv, 8'h00);
        give_verdict();
    end
    // whole run is under two hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule
bind cell_balance_nvm cell_balance_chk #(.CELLS(CELLS)) chk (
    .core_clk(core_clk),
    .rstn(rstn),
    .comm_enable_pin(comm_enable_pin),
    .host_addr(host_addr),
    .host_wdata(host_wdata),
    .host_wr(host_wr),
    .host_lines_en(host_lines_en),
    .parity_error(parity_error),
    .bleed_en(bleed_en),
    .balance_active(balance_active),
    .nv_commit(nv_commit),
    .nv_preread_en(nv_preread_en),
    .cfg_write_en(cfg_write_en),
    .fet_drive(fet_drive)
);
`default_nettype wire
